//--- dua_pkg.sv
// Purpose: shared constants for the serial controller auxiliary block
// Assumes: byte-wide register port with a four-bit address
// Notes:   offsets, field positions, codes and reset values live here
`default_nettype none

package dua_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_AUX_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_INT_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_INT_MASK      = 4'h2;
  localparam logic [3:0] ADDR_PRELOAD_UPPER = 4'h3;
  localparam logic [3:0] ADDR_PRELOAD_LOWER = 4'h4;
  localparam logic [3:0] ADDR_LIVE_UPPER    = 4'h5;
  localparam logic [3:0] ADDR_LIVE_LOWER    = 4'h6;
  localparam logic [3:0] ADDR_SCRATCHPAD    = 4'h7;
  localparam logic [3:0] ADDR_INPUT_LEVELS  = 4'h8;
  localparam logic [3:0] ADDR_OUT_ROUTING   = 4'h9;
  localparam logic [3:0] ADDR_INPUT_CHANGE  = 4'hA;
  localparam logic [3:0] ADDR_TIMER_START   = 4'hB;
  localparam logic [3:0] ADDR_TIMER_STOP    = 4'hC;
  localparam logic [3:0] ADDR_OUT_SET       = 4'hD;
  localparam logic [3:0] ADDR_OUT_CLEAR     = 4'hE;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int          ACR_BAUD_BIT   = 7;
  localparam int          ACR_TIMER_BIT  = 6;
  localparam int          ISR_TX_A       = 0;
  localparam int          ISR_RX_A       = 1;
  localparam int          ISR_BRK_A      = 2;
  localparam int          ISR_CT_RDY     = 3;
  localparam int          ISR_TX_B       = 4;
  localparam int          ISR_RX_B       = 5;
  localparam int          ISR_BRK_B      = 6;
  localparam int          ISR_IN_CHANGE  = 7;
  localparam logic [3:0]  CMD_BRK_RESET  = 4'h5;
  localparam logic [3:0]  PRESCALE_LAST  = 4'hF;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [15:0] COUNT_ONE      = 16'h0001;

  // clock source and mode codes of the counter/timer field
  typedef enum logic [2:0] {
    CT_CNT_IN2     = 3'b000,
    CT_CNT_TXA     = 3'b001,
    CT_CNT_TXB     = 3'b010,
    CT_CNT_XTAL16  = 3'b011,
    CT_TMR_IN2     = 3'b100,
    CT_TMR_IN2_16  = 3'b101,
    CT_TMR_XTAL    = 3'b110,
    CT_TMR_XTAL16  = 3'b111
  } dua_ct_src_t;

  // routing codes for multi-purpose output 2
  typedef enum logic [1:0] {
    OP2_PORT    = 2'b00,
    OP2_TXA_X16 = 2'b01,
    OP2_TXA_X1  = 2'b10,
    OP2_RXA_X1  = 2'b11
  } dua_op2_sel_t;

endpackage : dua_pkg

`default_nettype wire

//--- dua_aux.sv
// Purpose: interrupt gathering, counter/timer and port aux registers
// Assumes: clk is the crystal clock; channel clocks share its domain
// Notes:   pins multi_in pass three flops before any edge is seen
//
// Our own choices: the strobed register port and the address map.
`default_nettype none

// What this block does
// - low control bits enable input-change interrupts
// - three-bit field picks counter/timer mode, clock
// - top control bit picks baud table set
// - interrupt pin is inverted OR of masked status
// - status read shows all, clears nothing
// - reset clears every latched interrupt source; ready bits follow the channels
// - transmit ready bits follow FIFO space
// - receive ready bits follow FIFO fill
// - break change bits cleared by command 0x5
// - ready bit set at count end or timer rise, stop clears
// - input change bit cleared by change register read
// - mask gates pin only, not status
// - preload bytes and live count registers
// - counter start reloads preload, fresh count
// - timer ignores stop except clearing ready
// - timer preload change applies next half-period
// - scratchpad byte stores and returns data
// - input levels register, bit seven zero
// - routing bits select output two source
// - outputs zero, one follow channel mode bits
// - start and stop register reads control counter
// - change register latches edges, read clears
module dua_aux
(
  input  wire logic       clk,               // crystal clock
  input  wire logic       arst_n,            // async reset, active low
  input  wire logic [3:0] addr,              // register address
  input  wire logic [7:0] wdata,             // write data
  input  wire logic       wr,                // write strobe
  input  wire logic       rd,                // read strobe
  output var  logic [7:0] rdata,             // read data, cycle after rd
  input  wire logic [6:0] multi_in,          // multi-purpose input pins
  input  wire logic       tx_ready_a,        // channel a tx space level
  input  wire logic       rx_ready_a,        // channel a rx fill level
  input  wire logic       tx_ready_b,        // channel b tx space level
  input  wire logic       rx_ready_b,        // channel b rx fill level
  input  wire logic       brk_change_a,      // channel a break edge pulse
  input  wire logic       brk_change_b,      // channel b break edge pulse
  input  wire logic       chan_a_command_wr, // channel a command write
  input  wire logic       chan_b_command_wr, // channel b command write
  input  wire logic [7:0] command_data,      // command byte written
  input  wire logic       chan_a_tx_clk_x1,  // channel a tx 1x clock
  input  wire logic       chan_a_tx_clk_x16, // channel a tx 16x clock
  input  wire logic       chan_a_rx_clk_x1,  // channel a rx 1x clock
  input  wire logic       chan_b_tx_clk_x1,  // channel b tx 1x clock
  input  wire logic       chan_a_alt_en,     // chan_a_mode1 b7 | mode2 b5
  input  wire logic       chan_b_alt_en,     // chan_b_mode1 b7 | mode2 b5
  input  wire logic       chan_a_alt_out,    // channel a alternate output
  input  wire logic       chan_b_alt_out,    // channel b alternate output
  output var  logic       int_n,             // interrupt, active low
  output var  logic       baud_set2,         // baud table set 2 chosen
  output var  logic       ct_out,            // counter/timer output
  output var  logic       multi_out_0,       // output pin 0
  output var  logic       multi_out_1,       // output pin 1
  output var  logic       multi_out_2        // output pin 2
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]  aux_control_r;     // mode, baud and enable bits
  logic [7:0]  interrupt_mask_r;  // pin gating mask
  logic [7:0]  preload_upper_r;   // reload value, upper byte
  logic [7:0]  preload_lower_r;   // reload value, lower byte
  logic [7:0]  scratchpad_r;      // user byte
  logic [1:0]  output_routing_r;  // output 2 source select
  logic [2:0]  port_assert_r;     // general outputs asserted low
  logic [6:0]  in_s1_r;           // first sync stage
  logic [6:0]  in_s2_r;           // second sync stage
  logic [6:0]  in_s3_r;           // third sync stage
  logic [6:0]  in_lvl_r;          // settled input levels
  logic [1:0]  warm_r;            // sync chain fill count after reset
  logic        warm_done;         // chain full, edges may count
  logic [3:0]  in_change_r;       // latched change bits
  logic        brk_a_r;           // channel a break change flag
  logic        brk_b_r;           // channel b break change flag
  logic        ct_rdy_r;          // counter/timer ready flag
  logic        in_irq_r;          // input change status flag
  logic [15:0] count_r;           // live count
  logic        running_r;         // counter/timer running
  logic [3:0]  xtal_div_r;        // crystal divide by 16
  logic [3:0]  in2_div_r;         // input 2 divide by 16
  logic        txa_d_r;           // channel a tx 1x delayed
  logic        txb_d_r;           // channel b tx 1x delayed
  logic [7:0]  rdata_nxt;         // read mux output
  logic [7:0]  interrupt_status;               // assembled status byte
  logic [6:0]  in_stable;         // stages two and three agree
  logic [6:0]  in_edge;           // settled change this cycle
  logic        timer_mode;        // field top bit high
  logic        start_cmd;         // start register read
  logic        stop_cmd;          // stop register read
  logic        ct_tick;           // one count step
  logic        tc_evt;            // counter terminal count
  logic        rise_evt;          // timer output rising
  logic        chg_evt;           // enabled input change
  logic        brk_a_clear;       // channel a break reset cmd
  logic        brk_b_clear;       // channel b break reset cmd
  logic        in_change_read;    // change register read

  // write decode helper
  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = wr && (addr == a);
  endfunction

  // read decode helper
  function automatic logic rd_hit(input logic [3:0] a);
    rd_hit = rd && (addr == a);
  endfunction

  // ****************************************************************
  // register writes
  // ****************************************************************
  // plain write registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aux_control_r    <= dua_pkg::RESET_BYTE;
      interrupt_mask_r <= dua_pkg::RESET_BYTE;
      preload_upper_r  <= dua_pkg::RESET_BYTE;
      preload_lower_r  <= dua_pkg::RESET_BYTE;
      scratchpad_r     <= dua_pkg::RESET_BYTE;
      output_routing_r <= 2'h0;
    end
    else
    begin
      if (wr_hit(dua_pkg::ADDR_AUX_CONTROL))
        aux_control_r <= wdata;
      if (wr_hit(dua_pkg::ADDR_INT_MASK))
        interrupt_mask_r <= wdata;
      if (wr_hit(dua_pkg::ADDR_PRELOAD_UPPER))
        preload_upper_r <= wdata;
      if (wr_hit(dua_pkg::ADDR_PRELOAD_LOWER))
        preload_lower_r <= wdata;
      if (wr_hit(dua_pkg::ADDR_SCRATCHPAD))
        scratchpad_r <= wdata;
      if (wr_hit(dua_pkg::ADDR_OUT_ROUTING))
        output_routing_r <= wdata[1:0];
    end
  end

  // general purpose outputs: set asserts, clear negates
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      port_assert_r <= 3'h0;
    else
      port_assert_r <= (port_assert_r
        & ~(wr_hit(dua_pkg::ADDR_OUT_CLEAR) ? wdata[2:0] : 3'h0))
        | (wr_hit(dua_pkg::ADDR_OUT_SET) ? wdata[2:0] : 3'h0);
  end

  // ****************************************************************
  // input synchroniser and change detect
  // ****************************************************************
  // three flop chain per input
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_s1_r  <= 7'h00;
      in_s2_r  <= 7'h00;
      in_s3_r  <= 7'h00;
      in_lvl_r <= 7'h00;
      warm_r   <= 2'h0;
    end
    else
    begin
      in_s1_r <= multi_in;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      // until the chain is full, levels copy stage two, no false edge
      if (!warm_done)
      begin
        warm_r   <= warm_r + 2'h1;
        in_lvl_r <= in_s2_r;
      end
      else
        // a level only moves once stages two and three agree
        in_lvl_r <= (in_lvl_r & ~in_stable) | (in_s3_r & in_stable);
    end
  end

  assign warm_done = (warm_r == 2'h3);
  assign in_stable = ~(in_s2_r ^ in_s3_r);
  assign in_edge   = {7{warm_done}} & in_stable & (in_s3_r ^ in_lvl_r);
  assign in_change_read = rd_hit(dua_pkg::ADDR_INPUT_CHANGE);
  // enabled change of inputs 0 to 3
  assign chg_evt = |(in_edge[3:0] & aux_control_r[3:0]);

  // change bits latch, read clears, new edge wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      in_change_r <= 4'h0;
    else
      in_change_r <= (in_change_read ? 4'h0 : in_change_r)
                     | in_edge[3:0];
  end

  // ****************************************************************
  // interrupt sources
  // ****************************************************************
  assign brk_a_clear = chan_a_command_wr
                       && (command_data[7:4] == dua_pkg::CMD_BRK_RESET);
  assign brk_b_clear = chan_b_command_wr
                       && (command_data[7:4] == dua_pkg::CMD_BRK_RESET);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      brk_a_r  <= 1'b0;
      brk_b_r  <= 1'b0;
      in_irq_r <= 1'b0;
      ct_rdy_r <= 1'b0;
    end
    else
    begin
      // break change, command clears, event wins
      brk_a_r  <= brk_change_a | (brk_a_r & ~brk_a_clear);
      brk_b_r  <= brk_change_b | (brk_b_r & ~brk_b_clear);
      in_irq_r <= chg_evt | (in_irq_r & ~in_change_read);
      // ready on count end or timer rise, stop clears
      ct_rdy_r <= tc_evt | rise_evt | (ct_rdy_r & ~stop_cmd);
    end
  end

  // status byte, levels follow the channels
  assign interrupt_status = {in_irq_r, brk_b_r, rx_ready_b, tx_ready_b,
                ct_rdy_r, brk_a_r, rx_ready_a, tx_ready_a};

  // masked OR, inverted onto the pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      int_n <= 1'b1;
    else
      int_n <= ~|(interrupt_status & interrupt_mask_r);
  end

  // ****************************************************************
  // counter/timer
  // ****************************************************************
  assign timer_mode = aux_control_r[dua_pkg::ACR_TIMER_BIT];
  assign start_cmd  = rd_hit(dua_pkg::ADDR_TIMER_START);
  assign stop_cmd   = rd_hit(dua_pkg::ADDR_TIMER_STOP);

  // prescalers and channel clock edge memory
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xtal_div_r <= 4'h0;
      in2_div_r  <= 4'h0;
      txa_d_r    <= 1'b0;
      txb_d_r    <= 1'b0;
    end
    else
    begin
      xtal_div_r <= xtal_div_r + 4'h1;
      if (in_edge[2] && in_s3_r[2])
        in2_div_r <= in2_div_r + 4'h1;
      txa_d_r <= chan_a_tx_clk_x1;
      txb_d_r <= chan_b_tx_clk_x1;
    end
  end

  always_comb
  begin
    case (dua_pkg::dua_ct_src_t'(aux_control_r[6:4]))
      dua_pkg::CT_CNT_IN2,
      dua_pkg::CT_TMR_IN2:    ct_tick = in_edge[2] && in_s3_r[2];
      dua_pkg::CT_CNT_TXA:    ct_tick = chan_a_tx_clk_x1 && !txa_d_r;
      dua_pkg::CT_CNT_TXB:    ct_tick = chan_b_tx_clk_x1 && !txb_d_r;
      dua_pkg::CT_TMR_IN2_16: ct_tick = in_edge[2] && in_s3_r[2]
                                && (in2_div_r == dua_pkg::PRESCALE_LAST);
      dua_pkg::CT_TMR_XTAL:   ct_tick = 1'b1;
      default:                ct_tick = xtal_div_r
                                == dua_pkg::PRESCALE_LAST;
    endcase
  end

  assign tc_evt   = !timer_mode && running_r && ct_tick && !start_cmd
                    && !stop_cmd && (count_r == dua_pkg::COUNT_ONE);
  assign rise_evt = timer_mode && running_r && ct_tick && !start_cmd
                    && !ct_out && (count_r <= dua_pkg::COUNT_ONE);

  // count, run state and output wave
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r   <= dua_pkg::RESET_WORD;
      running_r <= 1'b0;
      ct_out    <= 1'b1;
    end
    else if (start_cmd)
    begin
      count_r   <= {preload_upper_r, preload_lower_r};
      running_r <= 1'b1;
      ct_out    <= 1'b1;
    end
    else if (stop_cmd && !timer_mode)
    begin
      // counter halts, output returns high
      running_r <= 1'b0;
      ct_out    <= 1'b1;
    end
    else if (running_r && ct_tick)
    begin
      if (timer_mode)
      begin
        // reload each half-period with latest preload
        if (count_r <= dua_pkg::COUNT_ONE)
        begin
          count_r <= {preload_upper_r, preload_lower_r};
          ct_out  <= !ct_out;
        end
        else
          count_r <= count_r - dua_pkg::COUNT_ONE;
      end
      else
      begin
        // counter rolls over after terminal count, output low
        count_r <= count_r - dua_pkg::COUNT_ONE;
        if (tc_evt)
          ct_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // outputs and read port
  // ****************************************************************
  // baud set straight from the control bit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      baud_set2 <= 1'b0;
    else
      baud_set2 <= aux_control_r[dua_pkg::ACR_BAUD_BIT];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      multi_out_0 <= 1'b1;
      multi_out_1 <= 1'b1;
      multi_out_2 <= 1'b1;
    end
    else
    begin
      multi_out_0 <= chan_a_alt_en ? chan_a_alt_out : !port_assert_r[0];
      multi_out_1 <= chan_b_alt_en ? chan_b_alt_out : !port_assert_r[1];
      case (dua_pkg::dua_op2_sel_t'(output_routing_r))
        dua_pkg::OP2_PORT:    multi_out_2 <= !port_assert_r[2];
        dua_pkg::OP2_TXA_X16: multi_out_2 <= chan_a_tx_clk_x16;
        dua_pkg::OP2_TXA_X1:  multi_out_2 <= chan_a_tx_clk_x1;
        default:              multi_out_2 <= chan_a_rx_clk_x1;
      endcase
    end
  end

  // read mux; unmapped and command reads return zero
  always_comb
  begin
    if (addr == dua_pkg::ADDR_AUX_CONTROL)
      rdata_nxt = aux_control_r;
    else if (addr == dua_pkg::ADDR_INT_STATUS)
      rdata_nxt = interrupt_status;
    else if (addr == dua_pkg::ADDR_INT_MASK)
      rdata_nxt = interrupt_mask_r;
    else if (addr == dua_pkg::ADDR_PRELOAD_UPPER)
      rdata_nxt = preload_upper_r;
    else if (addr == dua_pkg::ADDR_PRELOAD_LOWER)
      rdata_nxt = preload_lower_r;
    // live count hidden in timer mode
    else if (addr == dua_pkg::ADDR_LIVE_UPPER)
      rdata_nxt = timer_mode ? 8'h00 : count_r[15:8];
    else if (addr == dua_pkg::ADDR_LIVE_LOWER)
      rdata_nxt = timer_mode ? 8'h00 : count_r[7:0];
    else if (addr == dua_pkg::ADDR_SCRATCHPAD)
      rdata_nxt = scratchpad_r;
    else if (addr == dua_pkg::ADDR_INPUT_LEVELS)
      rdata_nxt = {1'b0, in_lvl_r};
    else if (addr == dua_pkg::ADDR_INPUT_CHANGE)
      rdata_nxt = {in_change_r, in_lvl_r[3:0]};
    else
      rdata_nxt = 8'h00;
  end

  // read data register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence gpr_write_s;
    wr && addr == dua_pkg::ADDR_SCRATCHPAD;
  endsequence
  sequence gpr_read_s;
    rd && addr == dua_pkg::ADDR_SCRATCHPAD;
  endsequence

  int_pin_a: assert property (##1 int_n == $past(~|(interrupt_status & interrupt_mask_r)))
    else $error("interrupt pin disagrees with masked status");
  isr_read_a: assert property (rd_hit(dua_pkg::ADDR_INT_STATUS) && !brk_a_clear
      && !chan_a_command_wr && brk_a_r |=> brk_a_r)
    else $error("status read altered a source");
  brk_clear_a: assert property (brk_a_clear && !brk_change_a |=> !interrupt_status[2])
    else $error("break change bit not cleared by command");
  chg_set_a: assert property (chg_evt |=> interrupt_status[7] ##0 in_change_r != 4'h0)
    else $error("enabled input change did not set status");
  chg_read_a: assert property (in_change_read && in_edge[3:0] == 4'h0
      |=> in_change_r == 4'h0 && !in_irq_r)
    else $error("change register read did not clear");
  gpr_echo_a: assert property (gpr_write_s ##1 gpr_read_s |=>
      rdata == $past(scratchpad_r))
    else $error("scratchpad readback wrong");
  start_load_a: assert property (start_cmd |=>
      count_r == {preload_upper_r, preload_lower_r} && running_r)
    else $error("start did not reload the preload");
  timer_stop_a: assert property (timer_mode && stop_cmd && running_r
      && !start_cmd |=> running_r && !ct_rdy_r)
    else $error("timer stopped or ready kept");
  rdy_set_a: assert property (tc_evt |=> ct_rdy_r && !ct_out)
    else $error("terminal count did not set ready");
  op2_route_a: assert property (output_routing_r == 2'b10 ##1
      output_routing_r == 2'b10 |-> multi_out_2 == $past(chan_a_tx_clk_x1))
    else $error("output 2 not routed to tx 1x clock");

endmodule : dua_aux

`default_nettype wire

//--- dua_host.sv
// Purpose: host cpu model driving the register port
// Assumes: one access at a time, strobes one cycle long
// Notes:   released write data is inverted, never stale
`default_nettype none
module dua_host
(
  input  wire logic       clk,   // bus clock
  output var  logic [3:0] addr,  // register address
  output var  logic [7:0] wdata, // write data
  output var  logic       wr,    // write strobe
  output var  logic       rd,    // read strobe
  input  wire logic [7:0] rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write, data released to its inverse
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // write then read back to back, no idle cycle between strobes
  task automatic put_get(input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    wdata <= ~d;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
endmodule // dua_host
`default_nettype wire

//--- test_dua_aux.sv
// Purpose: self-checking bench for the auxiliary block
// Assumes: dua_host drives the register port
// Notes:   host changes the counter mode once with the timer still running,
//          reads the live count both while the timer runs and when
//          stopped, and changes the baud bit with channels idle
`default_nettype none
module test_dua_aux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, wr, rd, out0, out1, out2, ct_out;
  logic [3:0] addr, div = 4'h0, rdy = 4'h0;
  logic [7:0] wdata, rdata, d, v, m, cmd = 8'h00;
  logic [6:0] mi = 7'h00;
  logic       int_n, baud2, brk_a = 0, brk_b = 0, cw_a = 0, cw_b = 0;
  logic       alt = 1'b0, alt_o = 1'b0;
  int         fail_count = 0, checks_done = 0, cyc = 0, k;
  always #50 clk = ~clk;
  always @(posedge clk) div <= div + 4'h1;
  dua_host dua_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  dua_aux dua_aux_i (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .multi_in(mi),
    .tx_ready_a(rdy[0]), .rx_ready_a(rdy[1]), .tx_ready_b(rdy[2]),
    .rx_ready_b(rdy[3]), .brk_change_a(brk_a), .brk_change_b(brk_b),
    .chan_a_command_wr(cw_a), .chan_b_command_wr(cw_b),
    .command_data(cmd), .chan_a_tx_clk_x1(div[3]),
    .chan_a_tx_clk_x16(div[0]), .chan_a_rx_clk_x1(div[2]),
    .chan_b_tx_clk_x1(div[1]), .chan_a_alt_en(alt), .chan_b_alt_en(alt),
    .chan_a_alt_out(alt_o), .chan_b_alt_out(~alt_o), .int_n(int_n),
    .baud_set2(baud2), .ct_out(ct_out), .multi_out_0(out0),
    .multi_out_1(out1), .multi_out_2(out2));
  // expected status from the four ready levels
  function automatic logic [7:0] st(input logic [3:0] r);
    return {2'b00, r[3], r[2], 2'b00, r[1], r[0]};
  endfunction
  // expected output 2 per routing code, port path asserted low
  function automatic logic op2(input int c, input logic [3:0] q);
    return (c == 1) ? q[0] : (c == 2) ? q[3] : (c == 3) ? q[2] : 1'b0;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, logic [3:0] a, logic [7:0] e);
    dua_host_i.get(a, d);
    chk(n, e, d);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(32'haa1b_5a7b));
    rchk("status", dua_pkg::ADDR_INT_STATUS, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      v = (k == 0) ? 8'hff : 8'($urandom);
      dua_host_i.put_get(dua_pkg::ADDR_SCRATCHPAD, v, d);
      chk("scratch", v, d);
    end
    dua_host_i.put(dua_pkg::ADDR_AUX_CONTROL, 8'h80);
    rchk("aux", dua_pkg::ADDR_AUX_CONTROL, 8'h80);
    chk("baud2", 8'h01, {7'h00, baud2});
    mi <= 7'($urandom);
    repeat (6) @(posedge clk);
    rchk("levels", dua_pkg::ADDR_INPUT_LEVELS, {1'b0, mi});
    $display("test registers done");
    for (k = 0; k < 6; k++)
    begin
      rdy <= 4'($urandom);
      m = 8'($urandom);
      dua_host_i.put(dua_pkg::ADDR_INT_MASK, m);
      rchk("status", dua_pkg::ADDR_INT_STATUS, st(rdy));
      rchk("status", dua_pkg::ADDR_INT_STATUS, st(rdy));
      chk("int_n", {7'h00, ~|(st(rdy) & m)}, {7'h00, int_n});
    end
    rdy <= 4'h0;
    @(posedge clk);
    brk_a <= 1'b1;
    brk_b <= 1'b1;
    @(posedge clk);
    brk_a <= 1'b0;
    brk_b <= 1'b0;
    cmd <= 8'h40;
    cw_a <= 1'b1;
    @(posedge clk);
    cmd <= 8'h50;
    @(posedge clk);
    cw_a <= 1'b0;
    rchk("brk", dua_pkg::ADDR_INT_STATUS, 8'h40);
    cw_b <= 1'b1;
    @(posedge clk);
    cw_b <= 1'b0;
    rchk("brk", dua_pkg::ADDR_INT_STATUS, 8'h00);
    $display("test interrupts done");
    dua_host_i.get(dua_pkg::ADDR_INPUT_CHANGE, d);
    dua_host_i.put(dua_pkg::ADDR_AUX_CONTROL, 8'h01);
    mi[1] <= ~mi[1];
    repeat (6) @(posedge clk);
    rchk("chg_off", dua_pkg::ADDR_INT_STATUS, 8'h00);
    mi[0] <= ~mi[0];
    repeat (6) @(posedge clk);
    rchk("chg", dua_pkg::ADDR_INT_STATUS, 8'h80);
    rchk("input_change_register", dua_pkg::ADDR_INPUT_CHANGE, {4'h3, mi[3:0]});
    rchk("chg", dua_pkg::ADDR_INT_STATUS, 8'h00);
    rchk("input_change_register", dua_pkg::ADDR_INPUT_CHANGE, {4'h0, mi[3:0]});
    $display("test input change done");
    dua_host_i.put(dua_pkg::ADDR_AUX_CONTROL, 8'h60);
    dua_host_i.put(dua_pkg::ADDR_PRELOAD_LOWER, 8'h03);
    dua_host_i.get(dua_pkg::ADDR_TIMER_START, d);
    repeat (8) @(posedge clk);
    rchk("ct_rdy", dua_pkg::ADDR_INT_STATUS, 8'h08);
    rchk("live", dua_pkg::ADDR_LIVE_LOWER, 8'h00);
    dua_host_i.get(dua_pkg::ADDR_TIMER_STOP, d);
    rchk("ct_rdy", dua_pkg::ADDR_INT_STATUS, 8'h00);
    v = {7'h00, ct_out};
    repeat (4) @(posedge clk);
    chk("ct_run", ~v, {7'h7f, ct_out});
    dua_host_i.put(dua_pkg::ADDR_INT_MASK, 8'h00);
    dua_host_i.put(dua_pkg::ADDR_AUX_CONTROL, 8'h00);
    dua_host_i.put(dua_pkg::ADDR_PRELOAD_LOWER, 8'h02);
    mi[2] <= 1'b0;
    repeat (6) @(posedge clk);
    dua_host_i.get(dua_pkg::ADDR_TIMER_START, d);
    dua_host_i.get(dua_pkg::ADDR_TIMER_STOP, d);
    rchk("live", dua_pkg::ADDR_LIVE_LOWER, 8'h02);
    dua_host_i.get(dua_pkg::ADDR_TIMER_START, d);
    for (k = 0; k < 6; k++)
    begin
      mi[2] <= k[0];
      repeat (6) @(posedge clk);
    end
    rchk("ct_rdy", dua_pkg::ADDR_INT_STATUS, 8'h08);
    chk("ct_out", 8'h00, {7'h00, ct_out});
    dua_host_i.get(dua_pkg::ADDR_TIMER_STOP, d);
    chk("ct_out", 8'h01, {7'h00, ct_out});
    rchk("live", dua_pkg::ADDR_LIVE_UPPER, 8'hff);
    brk_a <= 1'b1;
    @(posedge clk);
    brk_a <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rchk("reset", dua_pkg::ADDR_INT_STATUS, 8'h00);
    rchk("input_change_register", dua_pkg::ADDR_INPUT_CHANGE, {4'h0, mi[3:0]});
    $display("test timer done");
    dua_host_i.put(dua_pkg::ADDR_OUT_SET, 8'h04);
    @(posedge clk);
    #1 chk("out2", 8'h00, {7'h00, out2});
    for (k = 0; k < 8; k++)
    begin
      if (k[0] == 1'b0)
        dua_host_i.put(dua_pkg::ADDR_OUT_ROUTING, 8'(k / 2));
      @(posedge clk);
      v = {7'h00, op2(k / 2, div)};
      #1 chk("out2", v, {7'h00, out2});
    end
    alt <= 1'b1;
    alt_o <= 1'($urandom);
    repeat (3) @(posedge clk);
    chk("out0", {7'h00, alt_o}, {7'h00, out0});
    chk("out1", {7'h00, ~alt_o}, {7'h00, out1});
    $display("test outputs done");
    stop_test();
  end
endmodule // test_dua_aux
`default_nettype wire
